/* verilog/ppsp_pkg.sv */
// Constants and types for the pipelined synchronous memory port
// Operation
// - Burst order strap: low gives linear, high gives interleaved sequence.
// - Selected only with primary and tertiary selects low, secondary high.
// - Reads return newest data, forwarded from the input data register.
// - Clock gate high makes a stall: only the pin synchronizers advance, no write done.
// - Cycle start low with read-not-write low begins a write.
// - Cycle start low with read-not-write high begins a read.
// - Sleep request high: ignore other inputs, all outputs released.
`default_nettype none
package ppsp_pkg;

  localparam int ADDR_W_DEF  = 17;
  localparam int DATA_W_DEF  = 18;
  localparam int LANES_DEF   = 2;
  localparam int BURST_W     = 2;
  localparam int SYNC_STAGES = 2;

  // Pin level meaning on the burst order strap
  typedef enum logic {
    PPSP_LINEAR      = 1'b0,
    PPSP_INTERLEAVED = 1'b1
  } ppsp_order_t;

  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic       VALID_RST     = 1'b0;
  localparam logic       OE_RST        = 1'b0;
  localparam logic       SYNC_RST      = 1'b0;

endpackage
`default_nettype wire

/* verilog/ppsp_burst_addr.sv */
// Burst address sequencer for the low address bits
`timescale 1ns/1ns
`default_nettype none
module ppsp_burst_addr #(
  parameter int W = ppsp_pkg::BURST_W
) (
  input  wire logic                 order,
  input  wire logic [W-1:0]         base,
  input  wire logic [W-1:0]         count,
  output logic      [W-1:0]         addr
);

  always_comb
  begin
    if (order == ppsp_pkg::PPSP_INTERLEAVED)
    begin
      addr = base ^ count;
    end
    else
    begin
      addr = base + count;
    end
  end

endmodule
`default_nettype wire

/* verilog/ppsp_port.sv */
// Pipelined synchronous memory port with late write and read forwarding
`timescale 1ns/1ns
`default_nettype none
module ppsp_port #(
  parameter int ADDR_W = ppsp_pkg::ADDR_W_DEF,
  parameter int DATA_W = ppsp_pkg::DATA_W_DEF,
  parameter int LANES  = ppsp_pkg::LANES_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 clk_gate_n,
  input  wire logic                 primary_select_n,
  input  wire logic                 secondary_select,
  input  wire logic                 tertiary_select_n,
  input  wire logic                 cycle_start_n,
  input  wire logic                 read_write_n,
  input  wire logic [LANES-1:0]     byte_lane_write_n,
  input  wire logic [ADDR_W-1:0]    address,
  input  wire logic [DATA_W-1:0]    dq_in,
  output logic      [DATA_W-1:0]    dq_out,
  output logic                      dq_oe,
  input  wire logic                 output_enable_n,
  input  wire logic                 burst_order,
  input  wire logic                 sleep_request
);

  localparam int LW    = DATA_W / LANES;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BW    = ppsp_pkg::BURST_W;

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous pins pass two flops before use
  logic [1:0] sleep_sync_q, oen_sync_q, order_sync_q;
  logic [1:0] sleep_sync_d, oen_sync_d, order_sync_d;

  always_comb
  begin
    sleep_sync_d = {sleep_sync_q[0], sleep_request};
    oen_sync_d   = {oen_sync_q[0], output_enable_n};
    order_sync_d = {order_sync_q[0], burst_order};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sleep_sync_q <= {2{ppsp_pkg::SYNC_RST}};
      oen_sync_q   <= {2{1'b1}};
      order_sync_q <= {2{ppsp_pkg::SYNC_RST}};
    end
    else
    begin
      sleep_sync_q <= sleep_sync_d;
      oen_sync_q   <= oen_sync_d;
      order_sync_q <= order_sync_d;
    end
  end

  logic sleep;
  logic stall;
  logic selected;
  assign sleep    = sleep_sync_q[1];
  // Edge is ignored when the gate is high
  assign stall    = clk_gate_n;
  assign selected = !primary_select_n && !tertiary_select_n
                    && secondary_select;

  ////////////////////////////////////////////////////////////////////////////
  // Command and burst tracking
  logic              s1_vld_q, s1_vld_d, s2_vld_q, s2_vld_d;
  logic              s1_wr_q, s1_wr_d, s2_wr_q, s2_wr_d;
  logic [ADDR_W-1:0] s1_addr_q, s1_addr_d, s2_addr_q, s2_addr_d;
  logic [LANES-1:0]  s1_be_q, s1_be_d, s2_be_q, s2_be_d;
  logic              bst_act_q, bst_act_d;
  logic [ADDR_W-1:0] bst_base_q, bst_base_d;
  logic [BW-1:0]     bst_cnt_q, bst_cnt_d;
  logic [BW-1:0]     bst_low;
  logic [BW-1:0]     bst_next_cnt;

  assign bst_next_cnt = bst_cnt_q + 2'h1;

  ppsp_burst_addr #(.W(BW)) u_burst (
    .order (order_sync_q[1]),
    .base  (bst_base_q[BW-1:0]),
    .count (bst_next_cnt),
    .addr  (bst_low)
  );

  always_comb
  begin
    s1_vld_d   = s1_vld_q;
    s1_wr_d    = s1_wr_q;
    s1_addr_d  = s1_addr_q;
    s1_be_d    = s1_be_q;
    s2_vld_d   = s2_vld_q;
    s2_wr_d    = s2_wr_q;
    s2_addr_d  = s2_addr_q;
    s2_be_d    = s2_be_q;
    bst_act_d  = bst_act_q;
    bst_base_d = bst_base_q;
    bst_cnt_d  = bst_cnt_q;
    if (sleep)
    begin
      // Pending operations are dropped on entry to sleep
      s1_vld_d  = 1'b0;
      s2_vld_d  = 1'b0;
      bst_act_d = 1'b0;
    end
    else if (!stall)
    begin
      s2_vld_d  = s1_vld_q;
      s2_wr_d   = s1_wr_q;
      s2_addr_d = s1_addr_q;
      s2_be_d   = s1_be_q;
      if (!cycle_start_n)
      begin
        s1_vld_d   = selected;
        s1_wr_d    = !read_write_n;
        s1_addr_d  = address;
        s1_be_d    = ~byte_lane_write_n;
        bst_act_d  = selected;
        bst_base_d = address;
        bst_cnt_d  = ppsp_pkg::BURST_CNT_RST;
      end
      else if (bst_act_q)
      begin
        // Burst repeats the last operation at the next address
        s1_vld_d   = 1'b1;
        s1_addr_d  = {bst_base_q[ADDR_W-1:BW], bst_low};
        s1_be_d    = ~byte_lane_write_n;
        bst_cnt_d  = bst_next_cnt;
      end
      else
      begin
        s1_vld_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_vld_q   <= ppsp_pkg::VALID_RST;
      s2_vld_q   <= ppsp_pkg::VALID_RST;
      s1_wr_q    <= 1'b0;
      s2_wr_q    <= 1'b0;
      s1_addr_q  <= '0;
      s2_addr_q  <= '0;
      s1_be_q    <= '0;
      s2_be_q    <= '0;
      bst_act_q  <= ppsp_pkg::VALID_RST;
      bst_base_q <= '0;
      bst_cnt_q  <= ppsp_pkg::BURST_CNT_RST;
    end
    else
    begin
      s1_vld_q   <= s1_vld_d;
      s2_vld_q   <= s2_vld_d;
      s1_wr_q    <= s1_wr_d;
      s2_wr_q    <= s2_wr_d;
      s1_addr_q  <= s1_addr_d;
      s2_addr_q  <= s2_addr_d;
      s1_be_q    <= s1_be_d;
      s2_be_q    <= s2_be_d;
      bst_act_q  <= bst_act_d;
      bst_base_q <= bst_base_d;
      bst_cnt_q  <= bst_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input data register holds the newest write until the next one
  logic              pw_vld_q, pw_vld_d;
  logic [ADDR_W-1:0] pw_addr_q, pw_addr_d;
  logic [DATA_W-1:0] pw_data_q, pw_data_d;
  logic [LANES-1:0]  pw_be_q, pw_be_d;
  logic              wr_take;
  logic              commit;
  logic [DATA_W-1:0] mem [DEPTH];

  assign wr_take = !sleep && !stall && s2_vld_q && s2_wr_q;
  // Write of the array is delayed one write, trading a compare for timing
  assign commit  = wr_take && pw_vld_q;

  always_comb
  begin
    pw_vld_d  = pw_vld_q;
    pw_addr_d = pw_addr_q;
    pw_data_d = pw_data_q;
    pw_be_d   = pw_be_q;
    if (wr_take)
    begin
      pw_vld_d  = 1'b1;
      pw_addr_d = s2_addr_q;
      pw_data_d = dq_in;
      pw_be_d   = s2_be_q;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pw_vld_q  <= ppsp_pkg::VALID_RST;
      pw_addr_q <= '0;
      pw_data_q <= '0;
      pw_be_q   <= '0;
    end
    else
    begin
      pw_vld_q  <= pw_vld_d;
      pw_addr_q <= pw_addr_d;
      pw_data_q <= pw_data_d;
      pw_be_q   <= pw_be_d;
    end
  end

  // Array is not reset; contents are undefined at power-up
  always_ff @(posedge clk)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (commit && pw_be_q[l])
      begin
        mem[pw_addr_q][l*LW +: LW] <= pw_data_q[l*LW +: LW];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data with forwarding, registered output and enable
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic              oe_q, oe_d;

  always_comb
  begin
    rd_data = mem[s2_addr_q];
    for (int l = 0; l < LANES; l++)
    begin
      if (pw_vld_q && pw_be_q[l] && pw_addr_q == s2_addr_q)
      begin
        rd_data[l*LW +: LW] = pw_data_q[l*LW +: LW];
      end
    end
  end

  always_comb
  begin
    dout_d = dout_q;
    oe_d   = oe_q;
    if (sleep)
    begin
      oe_d = 1'b0;
    end
    else if (!stall)
    begin
      oe_d = s2_vld_q && !s2_wr_q;
      if (s2_vld_q && !s2_wr_q)
      begin
        dout_d = rd_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dout_q <= '0;
      oe_q   <= ppsp_pkg::OE_RST;
    end
    else
    begin
      dout_q <= dout_d;
      oe_q   <= oe_d;
    end
  end

  assign dq_out = dout_q;
  assign dq_oe  = oe_q && !oen_sync_q[1] && !sleep;

endmodule
`default_nettype wire

/* test/ppsp_ctrl_model.sv */
// Controller side model: select drive and delayed write data
`timescale 1ns/1ns
`default_nettype none
module ppsp_ctrl_model (
  input  wire logic        clk,
  input  wire logic        clk_gate_n,
  input  wire logic        sel,
  input  wire logic        cycle_start_n,
  input  wire logic        read_write_n,
  input  wire logic [17:0] wdata,
  output logic             primary_select_n,
  output logic             secondary_select,
  output logic             tertiary_select_n,
  output logic [17:0]      dq_in
);
  logic [17:0] d1, d2;
  logic        wop, w1, w2;
  initial {d1, d2, wop, w1, w2} = '0;
  // All three selects move together
  assign primary_select_n  = !sel;
  assign secondary_select  = sel;
  assign tertiary_select_n = !sel;
  // Released bus shows inverse so stale data never matches
  assign dq_in = w2 ? d2 : ~d2;
  // Data two enabled edges after its command
  always @(posedge clk)
    if (!clk_gate_n)
    begin
      d1  <= wdata;
      d2  <= d1;
      w2  <= w1;
      wop <= cycle_start_n ? wop : (!read_write_n && sel);
      w1  <= cycle_start_n ? wop : (!read_write_n && sel);
    end
endmodule
`default_nettype wire

/* test/ppsp_port_chk.sv */
// Checker for the memory port output timing
`timescale 1ns/1ns
`default_nettype none
module ppsp_port_chk #(
  parameter int DATA_W = ppsp_pkg::DATA_W_DEF
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              clk_gate_n,
  input wire logic              primary_select_n,
  input wire logic              secondary_select,
  input wire logic              tertiary_select_n,
  input wire logic              cycle_start_n,
  input wire logic              read_write_n,
  input wire logic              output_enable_n,
  input wire logic              sleep_request,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe
);
  logic sel, ok, rd, q;
  assign sel = !primary_select_n && secondary_select && !tertiary_select_n;
  assign ok  = !clk_gate_n && !output_enable_n && !sleep_request;
  assign rd  = ok && sel && !cycle_start_n && read_write_n;
  assign q   = !sleep_request && !output_enable_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd_go;
    !sleep_request [*2] ##1 rd;
  endsequence
  chk_sleep_off: assert property (sleep_request [*3] |=> !dq_oe)
    else $error("output driven in sleep");
  chk_read_oe: assert property (rd_go ##1 ok ##1 ok |=> dq_oe)
    else $error("read data not driven");
  chk_stall_skip: assert property (rd_go ##1 (clk_gate_n && q)
    ##1 ok ##1 ok |=> dq_oe) else $error("stall counted as edge");
  chk_burst_oe: assert property (rd_go ##1 (ok && cycle_start_n)
    ##1 ok ##1 ok |-> dq_oe ##1 dq_oe) else $error("burst beat lost");
  chk_nonread_oe: assert property ((ok && !cycle_start_n
    && (!sel || !read_write_n)) ##1 !clk_gate_n ##1 !clk_gate_n |=> !dq_oe)
    else $error("drive without read");
  chk_stall_data: assert property (clk_gate_n |=> $stable(dq_out))
    else $error("data moved in stall");
  chk_stall_oe: assert property (q [*2] ##1 (q && clk_gate_n)
    |=> $stable(dq_oe)) else $error("enable moved in stall");
  chk_oe_source: assert property (dq_oe |-> !$past(sleep_request, 2)
    && !$past(output_enable_n, 2)) else $error("drive too early");
  cov_read: cover property (rd_go);
  cov_stall: cover property (clk_gate_n && !cycle_start_n);
  cov_sleep: cover property (sleep_request [*3]);
endmodule
bind ppsp_port ppsp_port_chk #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

/* test/ppsp_port_tb_top.sv */
// Testbench for the pipelined synchronous memory port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin check_count++; \
  if ((s) !== (e) || $isunknown(s)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module ppsp_port_tb_top;
  logic        clk, rstn, clk_gate_n, sel, cycle_start_n, read_write_n;
  logic        burst_order, sleep_request, psel_n, ssel, tsel_n, dq_oe, en_q;
  logic        oe_n, part;
  logic [1:0]  lane_n;
  logic [16:0] address, ad;
  logic [17:0] wdata, dq_in, dq_out, exp_d;
  logic [17:0] mem [int];
  logic [17:0] q [$];
  int          fails, check_count;
  ppsp_ctrl_model u_ctrl (.clk(clk), .clk_gate_n(clk_gate_n), .sel(sel),
    .cycle_start_n(cycle_start_n), .read_write_n(read_write_n),
    .wdata(wdata), .primary_select_n(psel_n), .secondary_select(ssel),
    .tertiary_select_n(tsel_n), .dq_in(dq_in));
  ppsp_port u_dut (.clk(clk), .rstn(rstn), .clk_gate_n(clk_gate_n),
    .primary_select_n(psel_n), .secondary_select(ssel),
    .tertiary_select_n(tsel_n), .cycle_start_n(cycle_start_n),
    .read_write_n(read_write_n), .byte_lane_write_n(lane_n),
    .address(address), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .output_enable_n(oe_n), .burst_order(burst_order),
    .sleep_request(sleep_request));
  task end_of_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One bus cycle; k notes the expected effect
  task cyc(input logic s_n, w, s, g, k, input logic [16:0] a,
           input logic [17:0] d);
    @(posedge clk);
    #1;
    cycle_start_n = s_n;
    read_write_n  = !w;
    sel           = s;
    clk_gate_n    = g;
    address       = a;
    wdata         = d;
    lane_n        = (part && w) ? 2'($urandom) : 2'h0;
    if (k && w)
      for (int l = 0; l < 2; l++)
        if (!lane_n[l])
          mem[a][l*9 +: 9] = d[l*9 +: 9];
    if (k && !w)
      q.push_back(mem[a]);
  endtask
  task idle(input int n);
    repeat (n) cyc(0, 0, 0, 0, 0, '0, '0);
  endtask
  // Stall edges carry no result, so only enabled edges pop
  always @(posedge clk) en_q <= !clk_gate_n;
  always @(negedge clk)
    if (en_q && dq_oe === 1'b1)
    begin
      `CHK("dq_oe", 1'b1, q.size() > 0)
      exp_d = q.pop_front();
      `CHK("dq_out", exp_d, dq_out)
    end
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #4000;
    fails++;
    end_of_test();
  end
  initial
  begin
    {rstn, clk_gate_n, sel, burst_order, sleep_request, oe_n, part} = '0;
    {cycle_start_n, read_write_n, address, wdata, lane_n} = '1;
    void'($urandom(32'habc3c2af));
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    for (int i = 0; i < 16; i++)
      cyc(0, i < 8 ? i[0] == 0 : 0, 1, 0, 1,
          17'(i < 8 ? i / 2 : i % 4), 18'($urandom));
    idle(3);
    $display("test read write done");
    cyc(0, 1, 1, 0, 1, 17'h3, 18'h155);
    cyc(0, 1, 1, 1, 0, 17'h3, 18'h2aa);
    cyc(0, 0, 1, 0, 1, 17'h3, '0);
    cyc(0, 1, 0, 0, 0, 17'h3, 18'h0f0);
    cyc(0, 0, 1, 0, 1, 17'h3, '0);
    cyc(0, 0, 1, 1, 0, 17'h5, '0);
    idle(3);
    $display("test stall done");
    for (int o = 0; o < 2; o++)
    begin
      burst_order = o[0];
      // Second pass writes random lanes over fully written words
      part = o[0];
      idle(3);
      for (int p = 0; p < 3; p++)
        for (int k = 0; k < 4; k++)
        begin
          ad = {15'h8, o[0] ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0]};
          cyc(!(p == 1 || k == 0), p == 0, 1, 0, 1, ad, 18'($urandom));
        end
      idle(3);
    end
    $display("test burst done");
    sleep_request = 1;
    repeat (4) cyc(0, 0, 1, 0, 0, 17'h3, '0);
    sleep_request = 0;
    idle(3);
    cyc(0, 0, 1, 0, 1, 17'h3, '0);
    idle(4);
    $display("test sleep done");
    // Read with output enable off must never drive the bus
    oe_n = 1;
    idle(2);
    cyc(0, 0, 1, 0, 0, 17'h3, '0);
    idle(3);
    oe_n = 0;
    idle(3);
    $display("test output enable done");
    `CHK("pending", 0, q.size())
    end_of_test();
  end
endmodule
`default_nettype wire
